// ### design/rsals_pkg.sv
// Constants for the remote target alias and link status register bank
package rsals_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int PORTS = 2;
  localparam logic [7:0] REG_TARGET0_ADDR = 8'h07;
  localparam logic [7:0] REG_TARGET0_ALIAS = 8'h08;
  localparam logic [7:0] REG_CRC_COUNT_LOW = 8'h0a;
  localparam logic [7:0] REG_CRC_COUNT_HIGH = 8'h0b;
  localparam logic [7:0] REG_LINK_STATUS = 8'h0c;
  localparam logic [7:0] RESET_VALUE = 8'h00;
  localparam logic [6:0] ADDR7_NONE = 7'h00;
  localparam int ADDR7_MSB = 7;
  localparam int ADDR7_LSB = 1;
  localparam int CRC_LO_MSB = 7;
  localparam int CRC_LO_LSB = 0;
  localparam int CRC_HI_MSB = 15;
  localparam int CRC_HI_LSB = 8;
  localparam logic [15:0] CRC_COUNT_ZERO = 16'h0000;
  localparam logic [15:0] CRC_COUNT_ONE = 16'h0001;
  localparam logic [15:0] CRC_COUNT_MAX = 16'hffff;
  localparam int ST_SELF_TEST_CRC = 3;
  localparam int ST_PIXEL_CLOCK = 2;
  localparam int ST_NORMAL_CRC = 1;
  localparam int ST_LINK = 0;
endpackage

// ### design/rsals_bank.sv
// Remote target alias remap, back-channel CRC counter and link status bank
//
// Behaviour
// - Each port keeps a 7-bit remote target 0 address in bits 7:1 of register 0x07.
// - A local transaction to the target 0 alias is forwarded with the stored target address, port 1's on a same-cycle double hit.
// - Each port keeps a 7-bit alias for remote target 0 in bits 7:1 of register 0x08.
// - A zero target address or zero alias blocks all access to remote target 0.
// - A 16-bit read-only count of back-channel CRC errors sits at 0x0a/0x0b, cleared by CRC reset.
// - Status bit 3 sets on back-channel CRC errors during self-test.
// - Status bit 3 clears on link loss, self-test restart or CRC reset.
// - Status bit 2 follows valid pixel clock presence.
// - Status bit 1 sets on CRC errors during normal traffic.
// - Status bit 1 clears on link loss or CRC reset.
// - Status bit 0 reads one while a cable link is present.
// - With the second-port view select set, per-port fields refer to the second port.
`timescale 1ns/1ns
module rsals_bank
  import rsals_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Register access from the control bus slave
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic second_port_view_select,
  input wire logic crc_reset,
  // Per-port link events and the shared pixel clock valid pin
  input wire logic [PORTS-1:0] backchannel_crc_error,
  input wire logic [PORTS-1:0] link_self_test_active,
  input wire logic [PORTS-1:0] link_self_test_start,
  input wire logic [PORTS-1:0] link_present_pin,
  input wire logic pixel_clock_valid_pin,
  // Local transaction address remap
  input wire logic [PORTS-1:0] remap_valid,
  input wire logic [6:0] local_addr,
  output logic [PORTS-1:0] remap_hit,
  output logic [6:0] remap_addr
);

  typedef struct packed {
    logic [PORTS-1:0][6:0] target;
    logic [PORTS-1:0][6:0] alias_addr;
    logic [PORTS-1:0][15:0] crc_count;
    logic [PORTS-1:0] self_test_err;
    logic [PORTS-1:0] normal_err;
    logic [PORTS-1:0] link_meta;
    logic [PORTS-1:0] link_sync;
    logic pclk_meta;
    logic pclk_sync;
    logic [DATA_W-1:0] rdata;
    logic [PORTS-1:0] hit;
    logic [6:0] raddr;
  } rsals_state_t;

  rsals_state_t st_reg;
  rsals_state_t st_next;
  logic sel;

  // Access to remote target 0 needs both addresses nonzero
  function automatic logic rsals_enabled(input logic [6:0] t, input logic [6:0] a);
    return (t != ADDR7_NONE) && (a != ADDR7_NONE);
  endfunction

  assign sel = second_port_view_select;

  always_comb begin
    st_next = st_reg;
    st_next.link_meta = link_present_pin;
    st_next.link_sync = st_reg.link_meta;
    st_next.pclk_meta = pixel_clock_valid_pin;
    st_next.pclk_sync = st_reg.pclk_meta;
    st_next.hit = '0;
    st_next.raddr = st_reg.raddr;
    for (int p = 0; p < PORTS; p++) begin
      // Counter saturates rather than wrap to keep a nonzero reading
      if (crc_reset) begin
        st_next.crc_count[p] = CRC_COUNT_ZERO;
      end else if (backchannel_crc_error[p] && st_reg.crc_count[p] != CRC_COUNT_MAX) begin
        st_next.crc_count[p] = st_reg.crc_count[p] + CRC_COUNT_ONE;
      end
      // Event wins over the restart clear so no error is lost
      if (backchannel_crc_error[p] && link_self_test_active[p] && st_reg.link_sync[p]) begin
        st_next.self_test_err[p] = 1'b1;
      end else if (!st_reg.link_sync[p] || link_self_test_start[p] || crc_reset) begin
        st_next.self_test_err[p] = 1'b0;
      end
      if (backchannel_crc_error[p] && !link_self_test_active[p] && st_reg.link_sync[p]) begin
        st_next.normal_err[p] = 1'b1;
      end else if (!st_reg.link_sync[p] || crc_reset) begin
        st_next.normal_err[p] = 1'b0;
      end
      // Port 1 overrides port 0 on a same-cycle double hit
      if (remap_valid[p] && rsals_enabled(st_reg.target[p], st_reg.alias_addr[p])
          && local_addr == st_reg.alias_addr[p]) begin
        st_next.hit[p] = 1'b1;
        st_next.raddr = st_reg.target[p];
      end
    end
    if (reg_wr) begin
      unique case (reg_addr)
        REG_TARGET0_ADDR: st_next.target[sel] = reg_wdata[ADDR7_MSB:ADDR7_LSB];
        REG_TARGET0_ALIAS: st_next.alias_addr[sel] = reg_wdata[ADDR7_MSB:ADDR7_LSB];
        default: ;
      endcase
    end
    // Read data is a pure view; nothing is cleared on read
    st_next.rdata = RESET_VALUE;
    if (reg_rd) begin
      unique case (reg_addr)
        REG_TARGET0_ADDR: st_next.rdata = {st_reg.target[sel], 1'b0};
        REG_TARGET0_ALIAS: st_next.rdata = {st_reg.alias_addr[sel], 1'b0};
        REG_CRC_COUNT_LOW: st_next.rdata = st_reg.crc_count[sel][CRC_LO_MSB:CRC_LO_LSB];
        REG_CRC_COUNT_HIGH: st_next.rdata = st_reg.crc_count[sel][CRC_HI_MSB:CRC_HI_LSB];
        REG_LINK_STATUS: begin
          st_next.rdata[ST_SELF_TEST_CRC] = st_reg.self_test_err[sel];
          st_next.rdata[ST_PIXEL_CLOCK] = st_reg.pclk_sync;
          st_next.rdata[ST_NORMAL_CRC] = st_reg.normal_err[sel];
          st_next.rdata[ST_LINK] = st_reg.link_sync[sel];
        end
        default: st_next.rdata = RESET_VALUE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata = st_reg.rdata;
  assign remap_hit = st_reg.hit;
  assign remap_addr = st_reg.raddr;

  // Checks look at the registered view, one cycle after the event that they follow
  property p_target_write;
    @(posedge clk) disable iff (!rst_b)
      reg_wr && reg_addr == REG_TARGET0_ADDR && !sel
      |=> st_reg.target[0] == $past(reg_wdata[ADDR7_MSB:ADDR7_LSB]);
  endproperty
  a_target_write: assert property (p_target_write)
    else $error("target write lost");

  property p_target_write_second;
    @(posedge clk) disable iff (!rst_b)
      reg_wr && reg_addr == REG_TARGET0_ADDR && sel
      |=> st_reg.target[1] == $past(reg_wdata[ADDR7_MSB:ADDR7_LSB]);
  endproperty
  a_target_write_second: assert property (p_target_write_second)
    else $error("second target write lost");

  property p_alias_write;
    @(posedge clk) disable iff (!rst_b)
      reg_wr && reg_addr == REG_TARGET0_ALIAS && sel
      |=> st_reg.alias_addr[1] == $past(reg_wdata[ADDR7_MSB:ADDR7_LSB]);
  endproperty
  a_alias_write: assert property (p_alias_write)
    else $error("alias write lost");

  property p_alias_write_first;
    @(posedge clk) disable iff (!rst_b)
      reg_wr && reg_addr == REG_TARGET0_ALIAS && !sel
      |=> st_reg.alias_addr[0] == $past(reg_wdata[ADDR7_MSB:ADDR7_LSB]);
  endproperty
  a_alias_write_first: assert property (p_alias_write_first)
    else $error("first alias write lost");

  // A double hit carries the second port's target, so port 0 is checked alone
  property p_remap;
    @(posedge clk) disable iff (!rst_b)
      remap_hit[0] && !remap_hit[1]
      |-> remap_addr == $past(st_reg.target[0]);
  endproperty
  a_remap: assert property (p_remap)
    else $error("remap address wrong");

  property p_remap_second;
    @(posedge clk) disable iff (!rst_b)
      remap_hit[1]
      |-> remap_addr == $past(st_reg.target[1]);
  endproperty
  a_remap_second: assert property (p_remap_second)
    else $error("second remap address wrong");

  property p_hit_needs_match;
    @(posedge clk) disable iff (!rst_b)
      remap_hit[0]
      |-> $past(remap_valid[0]) && $past(local_addr) == $past(st_reg.alias_addr[0]);
  endproperty
  a_hit_needs_match: assert property (p_hit_needs_match)
    else $error("hit without alias match");

  property p_block;
    @(posedge clk) disable iff (!rst_b)
      remap_hit[0]
      |-> $past(st_reg.target[0]) != ADDR7_NONE && $past(st_reg.alias_addr[0]) != ADDR7_NONE;
  endproperty
  a_block: assert property (p_block)
    else $error("blocked target reached");

  property p_block_second;
    @(posedge clk) disable iff (!rst_b)
      remap_hit[1]
      |-> $past(st_reg.target[1]) != ADDR7_NONE && $past(st_reg.alias_addr[1]) != ADDR7_NONE;
  endproperty
  a_block_second: assert property (p_block_second)
    else $error("blocked second target reached");

  // An error in the reset cycle may still set its status bit
  property p_crc_clear;
    @(posedge clk) disable iff (!rst_b)
      crc_reset
      |=> st_reg.crc_count == '0 && (st_reg.normal_err & ~$past(backchannel_crc_error)) == '0;
  endproperty
  a_crc_clear: assert property (p_crc_clear)
    else $error("crc reset failed");

  property p_count_step;
    @(posedge clk) disable iff (!rst_b)
      !crc_reset && backchannel_crc_error[0] && st_reg.crc_count[0] != CRC_COUNT_MAX
      |=> st_reg.crc_count[0] == $past(st_reg.crc_count[0]) + CRC_COUNT_ONE;
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("crc count did not step");

  property p_count_read;
    @(posedge clk) disable iff (!rst_b)
      reg_rd && reg_addr == REG_CRC_COUNT_HIGH
      |=> reg_rdata == $past(st_reg.crc_count[sel][CRC_HI_MSB:CRC_HI_LSB]);
  endproperty
  a_count_read: assert property (p_count_read)
    else $error("count high byte read wrong");

  property p_self_test_set;
    @(posedge clk) disable iff (!rst_b)
      backchannel_crc_error[0] && link_self_test_active[0] && st_reg.link_sync[0]
      |=> st_reg.self_test_err[0];
  endproperty
  a_self_test_set: assert property (p_self_test_set)
    else $error("self-test error not set");

  property p_self_test_clear;
    @(posedge clk) disable iff (!rst_b)
      !st_reg.link_sync[0] && !backchannel_crc_error[0]
      |=> !st_reg.self_test_err[0];
  endproperty
  a_self_test_clear: assert property (p_self_test_clear)
    else $error("self-test error kept");

  property p_self_test_restart;
    @(posedge clk) disable iff (!rst_b)
      link_self_test_start[0] && !backchannel_crc_error[0]
      |=> !st_reg.self_test_err[0];
  endproperty
  a_self_test_restart: assert property (p_self_test_restart)
    else $error("self-test error kept over restart");

  property p_self_test_crc_reset;
    @(posedge clk) disable iff (!rst_b)
      crc_reset && !backchannel_crc_error[0]
      |=> !st_reg.self_test_err[0];
  endproperty
  a_self_test_crc_reset: assert property (p_self_test_crc_reset)
    else $error("self-test error kept over crc reset");

  property p_normal_set;
    @(posedge clk) disable iff (!rst_b)
      backchannel_crc_error[1] && !link_self_test_active[1] && st_reg.link_sync[1]
      |=> st_reg.normal_err[1];
  endproperty
  a_normal_set: assert property (p_normal_set)
    else $error("normal error not set");

  property p_normal_link_loss;
    @(posedge clk) disable iff (!rst_b)
      !st_reg.link_sync[1]
      |=> !st_reg.normal_err[1];
  endproperty
  a_normal_link_loss: assert property (p_normal_link_loss)
    else $error("normal error kept over link loss");

  property p_link_read;
    @(posedge clk) disable iff (!rst_b)
      reg_rd && reg_addr == REG_LINK_STATUS
      |=> reg_rdata[ST_LINK] == $past(st_reg.link_sync[sel])
        && reg_rdata[ST_PIXEL_CLOCK] == $past(st_reg.pclk_sync);
  endproperty
  a_link_read: assert property (p_link_read)
    else $error("status read wrong");

  property p_status_err_read;
    @(posedge clk) disable iff (!rst_b)
      reg_rd && reg_addr == REG_LINK_STATUS
      |=> reg_rdata[ST_SELF_TEST_CRC] == $past(st_reg.self_test_err[sel])
        && reg_rdata[ST_NORMAL_CRC] == $past(st_reg.normal_err[sel]);
  endproperty
  a_status_err_read: assert property (p_status_err_read)
    else $error("error bits read wrong");

  property p_read_keeps;
    @(posedge clk) disable iff (!rst_b)
      reg_rd && !crc_reset && backchannel_crc_error == '0
      |=> $stable(st_reg.crc_count);
  endproperty
  a_read_keeps: assert property (p_read_keeps)
    else $error("read changed counter");

  property p_rdata_idle;
    @(posedge clk) disable iff (!rst_b)
      !reg_rd
      |=> reg_rdata == RESET_VALUE;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data without a read");

endmodule

// ### test/rsals_far_end.sv
// Far-end deserializer model: link pins and CRC error bursts
`timescale 1ns/1ns
module rsals_far_end (
  // Bench control
  input wire logic clk,
  input wire logic [1:0] link_on,
  input wire logic [1:0] port,
  input wire logic [4:0] len,
  input wire logic go,
  input wire logic slow,
  // Device side, plus busy back to the bench
  output logic [1:0] link_pin,
  output logic [1:0] crc_err,
  output logic busy
);
  logic [4:0] left = 5'h00;
  logic gap = 1'b0;
  assign link_pin = link_on;
  assign busy = left != 5'h00;
  // Slow mode idles every other cycle between errors
  always @(posedge clk) begin
    crc_err <= 2'h0;
    gap <= ~gap;
    if (go) begin
      left <= len;
    end else if (busy && !(slow && gap)) begin
      crc_err <= port;
      left <= left - 5'h01;
    end
  end
endmodule

// ### test/remote_slave_alias_and_link_status_bench.sv
// Self-checking bench for the remote target alias and link status bank
`timescale 1ns/1ns
module remote_slave_alias_and_link_status_bench;
  logic clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, sel = 1'b0, crst = 1'b0;
  logic pclk = 1'b0, go = 1'b0, slow = 1'b0, busy;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic [1:0] st_act = 2'h0, st_go = 2'h0, rv = 2'h0, link_on = 2'h0, port = 2'h0;
  logic [1:0] hit, lpin, cerr;
  logic [6:0] la = 7'h00, raddr, tgt[2], ali[2];
  logic [4:0] len = 5'h00;
  int n_errors = 0, samples_checked = 0, seed = 1724, cnt, p;
  rsals_bank dut (.clk(clk), .rst_b(rst_b), .reg_wr(wr), .reg_rd(rd), .reg_addr(addr),
    .reg_wdata(wdata), .reg_rdata(rdata), .second_port_view_select(sel), .crc_reset(crst),
    .backchannel_crc_error(cerr), .link_self_test_active(st_act),
    .link_self_test_start(st_go), .link_present_pin(lpin), .pixel_clock_valid_pin(pclk),
    .remap_valid(rv), .local_addr(la), .remap_hit(hit), .remap_addr(raddr));
  rsals_far_end far (.clk(clk), .link_on(link_on), .port(port), .len(len), .go(go),
    .slow(slow), .link_pin(lpin), .crc_err(cerr), .busy(busy));
  initial forever #2 clk = ~clk;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rreg(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk) {rd, addr} = {1'b1, a};
    @(negedge clk) rd = 1'b0;
    check(16'(rdata), 16'(e));
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk) {wr, addr, wdata} = {1'b1, a, d};
    @(negedge clk) wr = 1'b0;
  endtask
  task automatic remap(input int q, input logic [6:0] a, input logic h, input logic [6:0] t);
    @(negedge clk) {rv, la} = {2'(1 << q), a};
    @(negedge clk) rv = 2'h0;
    check(16'(hit), 16'({1'b0, h} << q));
    if (h) check(16'(raddr), 16'(t));
  endtask
  task automatic burst(input int q, input int n);
    int k;
    @(negedge clk) {port, len, go} = {2'(1 << q), 5'(n), 1'b1};
    slow = 1'($random(seed));
    @(negedge clk) go = 1'b0;
    for (k = 0; k < 80 && busy; k++) @(negedge clk);
    if (busy) begin
      n_errors++;
      test_done();
    end
    repeat (2) @(negedge clk);
  endtask
  task automatic test_done();
    $display("checks %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #80000 n_errors++;
    test_done();
  end
  initial begin
    repeat (6) @(negedge clk);
    rst_b = 1'b1;
    for (p = 7; p < 13; p++) rreg(8'(p), 8'h00);
    for (p = 0; p < 2; p++) begin
      sel = 1'(p);
      tgt[p] = 7'($random(seed)) | 7'h01;
      ali[p] = 7'($random(seed)) | 7'h40;
      wreg(8'h07, {tgt[p], 1'b1});
      wreg(8'h08, {ali[p], 1'b1});
      remap(p, ali[p], 1'b1, tgt[p]);
      remap(p, ali[p] ^ 7'h01, 1'b0, tgt[p]);
    end
    for (p = 0; p < 2; p++) begin
      sel = 1'(p);
      rreg(8'h07, {tgt[p], 1'b0});
      rreg(8'h08, {ali[p], 1'b0});
    end
    wreg(8'h08, 8'h00);
    remap(1, 7'h00, 1'b0, 7'h00);
    sel = 1'b0;
    wreg(8'h07, 8'h01);
    remap(0, ali[0], 1'b0, 7'h00);
    $display("test registers and remap done");
    {link_on, pclk} = 3'b011;
    repeat (3) @(negedge clk);
    rreg(8'h0c, 8'h05);
    sel = 1'b1;
    rreg(8'h0c, 8'h04);
    burst(1, 3);
    rreg(8'h0a, 8'h03);
    rreg(8'h0c, 8'h04);
    sel = 1'b0;
    cnt = 1 + ($random(seed) & 15);
    burst(0, cnt);
    wreg(8'h0a, 8'hff);
    repeat (2) begin
      rreg(8'h0a, 8'(cnt));
      rreg(8'h0c, 8'h07);
    end
    rreg(8'h0b, 8'h00);
    st_act = 2'b01;
    burst(0, 2);
    rreg(8'h0a, 8'(cnt + 2));
    rreg(8'h0c, 8'h0f);
    @(negedge clk) st_go = 2'b01;
    @(negedge clk) st_go = 2'b00;
    rreg(8'h0c, 8'h07);
    burst(0, 1);
    @(negedge clk) crst = 1'b1;
    @(negedge clk) crst = 1'b0;
    rreg(8'h0a, 8'h00);
    rreg(8'h0c, 8'h05);
    burst(0, 1);
    st_act = 2'b00;
    burst(0, 1);
    rreg(8'h0c, 8'h0f);
    {link_on, pclk} = 3'b000;
    repeat (3) @(negedge clk);
    rreg(8'h0c, 8'h00);
    $display("test link events done");
    test_done();
  end
endmodule
